// file: logic/arr_result_regs.v
`timescale 1ns/1ps
module arr_result_regs (
   // clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // analog front end
   input  wire        cmp_hi,
   input  wire [3:0]  analog_pin_level,
   output reg  [9:0]  dac_code,
   output reg  [1:0]  mux_channel,
   output reg         comparator_enable,
   // interrupt
   output reg         conversion_done_interrupt
);
`include "arr_consts.vh"

   // state codes
   localparam ST_IDLE = 1'b0;
   localparam ST_CONV = 1'b1;

   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   reg  [9:0]  result_reg [0:3];     // per-channel results
   reg  [5:0]  mode_reg;             // converter_mode_control
   reg  [1:0]  imask_reg;            // interrupt mask, status layout
   reg         eoc_reg;              // end_of_conversion_flag
   reg         done_req_reg;         // conversion_done_request_flag
   reg         busy_reg;             // conversion_busy_flag
   reg         state_reg;            // sequencer state
   reg  [1:0]  chan_reg;             // channel under conversion
   reg  [3:0]  port_reg;             // shared_input_port sample
   reg         sar_start_reg;        // kicks the engine
   wire [9:0]  trial;
   wire        sar_done;
   integer     i;

   // apb access decode
   wire acc    = psel & penable;
   wire wr_acc = acc & pwrite;
   wire rd_acc = acc & ~pwrite;
   wire start_wr = wr_acc && paddr == `ARR_OFS_MODE && pwdata[`ARR_MODE_START];
   // any channel high-byte read
   wire hi_rd = rd_acc && (paddr == `ARR_OFS_RES0H || paddr == `ARR_OFS_RES1H ||
                           paddr == `ARR_OFS_RES2H || paddr == `ARR_OFS_RES3H);
   wire [1:0] chan_field = mode_reg[`ARR_MODE_CH_HI:`ARR_MODE_CH_LO];
   wire scan_mode  = mode_reg[`ARR_MODE_SCAN];
   wire rep_mode   = mode_reg[`ARR_MODE_REPEAT];
   wire last_chan  = !scan_mode || chan_reg == chan_field;
   wire finish_one = state_reg == ST_CONV && sar_done;
   // completion that ends a single-mode sequence
   wire seq_end    = finish_one && last_chan && !rep_mode;
   wire [1:0] status = {done_req_reg, eoc_reg};

   // ------------------------------------------------------------
   // conversion engine
   // ------------------------------------------------------------
   // shared engine
   arr_sar_step u_sar (
      .pclk      (pclk),
      .presetn   (presetn),
      .start     (sar_start_reg),
      .cmp_hi    (cmp_hi),
      .trial_reg (trial),
      .done_reg  (sar_done)
   );

   // ------------------------------------------------------------
   // sequencer and flags
   // ------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_reg      <= 6'h00;
         imask_reg     <= 2'h0;
         eoc_reg       <= 1'b0;
         done_req_reg  <= 1'b0;
         busy_reg      <= 1'b0;
         state_reg     <= ST_IDLE;
         chan_reg      <= 2'h0;
         sar_start_reg <= 1'b0;
         for (i = 0; i < 4; i = i + 1) begin
            result_reg[i] <= 10'h000;
         end
      end else begin
         sar_start_reg <= 1'b0;
         // mode and mask writes; start bit is self-clearing
         if (wr_acc && paddr == `ARR_OFS_MODE) begin
            mode_reg <= {pwdata[`ARR_MODE_CH_HI:`ARR_MODE_REPEAT], 1'b0, 1'b0} |
                        {5'h00, 1'b0} | {4'h0, pwdata[`ARR_MODE_SCAN], 1'b0};
         end
         if (wr_acc && paddr == `ARR_OFS_IMASK) begin
            imask_reg <= pwdata[1:0];
         end
         if (hi_rd) begin
            eoc_reg      <= 1'b0;
            done_req_reg <= 1'b0;
         end
         // write-one-to-clear of status
         if (wr_acc && paddr == `ARR_OFS_STAT) begin
            if (pwdata[`ARR_ST_EOC]) eoc_reg <= 1'b0;
            if (pwdata[`ARR_ST_DONE]) done_req_reg <= 1'b0;
         end
         case (state_reg)
            ST_IDLE: begin
               if (start_wr) begin
                  busy_reg      <= 1'b1;
                  state_reg     <= ST_CONV;
                  chan_reg      <= pwdata[`ARR_MODE_SCAN] ? 2'h0 : pwdata[`ARR_MODE_CH_HI:`ARR_MODE_CH_LO];
                  sar_start_reg <= 1'b1;
               end
            end
            ST_CONV: begin
               if (start_wr) begin
                  chan_reg      <= pwdata[`ARR_MODE_SCAN] ? 2'h0 : pwdata[`ARR_MODE_CH_HI:`ARR_MODE_CH_LO];
                  sar_start_reg <= 1'b1;
               end else if (sar_done && !sar_start_reg) begin
                  // a completion right after a restart belongs to the aborted run
                  // whole result at once
                  result_reg[chan_reg] <= trial;
                  if (!last_chan) begin
                     chan_reg      <= chan_reg + 2'h1;
                     sar_start_reg <= 1'b1;
                  end else if (rep_mode) begin
                     // repeat restarts the sequence
                     chan_reg      <= scan_mode ? 2'h0 : chan_field;
                     sar_start_reg <= 1'b1;
                  end else begin
                     busy_reg     <= 1'b0;
                     eoc_reg      <= 1'b1;
                     done_req_reg <= 1'b1;
                     state_reg    <= ST_IDLE;
                  end
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // read data and outputs
   // ------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata                    <= 32'h00000000;
         pready                    <= 1'b0;
         pslverr                   <= 1'b0;
         dac_code                  <= 10'h000;
         mux_channel               <= 2'h0;
         comparator_enable         <= 1'b0;
         conversion_done_interrupt <= 1'b0;
         port_reg                  <= 4'h0;
      end else begin
         port_reg          <= analog_pin_level;
         dac_code          <= trial;
         mux_channel       <= chan_reg;
         comparator_enable <= busy_reg & mode_reg[`ARR_MODE_SPEED];
         // unmasked sticky status drives the level
         conversion_done_interrupt <= |(status & imask_reg);
         // ready registered from setup so access completes with no wait state
         pready  <= psel & ~penable;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
         if (psel && !penable && !pwrite) begin
            if (paddr == `ARR_OFS_RES0L) begin
               prdata <= {24'h000000, result_reg[0][1:0], `ARR_LOW_FILL};
            end else if (paddr == `ARR_OFS_RES0H) begin
               prdata <= {24'h000000, result_reg[0][9:2]};
            end else if (paddr == `ARR_OFS_RES1L) begin
               prdata <= {24'h000000, result_reg[1][1:0], `ARR_LOW_FILL};
            end else if (paddr == `ARR_OFS_RES1H) begin
               prdata <= {24'h000000, result_reg[1][9:2]};
            end else if (paddr == `ARR_OFS_RES2L) begin
               prdata <= {24'h000000, result_reg[2][1:0], `ARR_LOW_FILL};
            end else if (paddr == `ARR_OFS_RES2H) begin
               prdata <= {24'h000000, result_reg[2][9:2]};
            end else if (paddr == `ARR_OFS_RES3L) begin
               prdata <= {24'h000000, result_reg[3][1:0], `ARR_LOW_FILL};
            end else if (paddr == `ARR_OFS_RES3H) begin
               prdata <= {24'h000000, result_reg[3][9:2]};
            end else if (paddr == `ARR_OFS_MODE) begin
               prdata <= {26'h0000000, mode_reg};
            end else if (paddr == `ARR_OFS_STAT) begin
               prdata <= {29'h00000000, busy_reg, done_req_reg, eoc_reg};
            end else if (paddr == `ARR_OFS_IMASK) begin
               prdata <= {30'h00000000, imask_reg};
            end else if (paddr == `ARR_OFS_PORT) begin
               prdata <= {28'h0000000, port_reg};
            end else begin
               // unmapped address
               pslverr <= 1'b1;
            end
         end else if (psel && !penable) begin
            if (paddr != `ARR_OFS_MODE && paddr != `ARR_OFS_STAT && paddr != `ARR_OFS_IMASK) begin
               pslverr <= 1'b1;
            end
         end
      end
   end
endmodule // arr_result_regs

// file: logic/arr_consts.vh
`ifndef ARR_CONSTS_VH
`define ARR_CONSTS_VH
// ---------------------------------------------------------------
// register byte addresses
// ---------------------------------------------------------------
`define ARR_OFS_RES0L   8'h60
`define ARR_OFS_RES0H   8'h61
`define ARR_OFS_RES1L   8'h62
`define ARR_OFS_RES1H   8'h63
`define ARR_OFS_RES2L   8'h64
`define ARR_OFS_RES2H   8'h65
`define ARR_OFS_RES3L   8'h66
`define ARR_OFS_RES3H   8'h67
`define ARR_OFS_MODE    8'h68
`define ARR_OFS_STAT    8'h6C
`define ARR_OFS_IMASK   8'h70
`define ARR_OFS_PORT    8'h74
// ---------------------------------------------------------------
// mode register fields
// ---------------------------------------------------------------
`define ARR_MODE_START  0
`define ARR_MODE_SCAN   1
`define ARR_MODE_REPEAT 2
`define ARR_MODE_SPEED  3
`define ARR_MODE_CH_LO  4
`define ARR_MODE_CH_HI  5
// ---------------------------------------------------------------
// status register fields
// ---------------------------------------------------------------
`define ARR_ST_EOC      0
`define ARR_ST_DONE     1
`define ARR_ST_BUSY     2
// ---------------------------------------------------------------
// widths and fixed values
// ---------------------------------------------------------------
`define ARR_RES_W       10
`define ARR_LOW_FILL    6'h3F
`define ARR_SAR_CYCLES  4'hA
`endif

// file: logic/arr_sar_step.v
`timescale 1ns/1ps
// one successive-approximation engine: ten compare steps, msb first
module arr_sar_step (
   // clock and reset
   input  wire       pclk,
   input  wire       presetn,
   // control
   input  wire       start,
   input  wire       cmp_hi,
   // results
   output reg  [9:0] trial_reg,
   output reg        done_reg
);
`include "arr_consts.vh"

   reg [9:0] bit_reg;   // bit under trial
   reg [3:0] cnt_reg;   // steps remaining
   reg       hold_reg;  // settling cycle before each decision

   // ------------------------------------------------------------
   // approximation sequence
   // ------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trial_reg <= 10'h000;
         bit_reg   <= 10'h000;
         cnt_reg   <= 4'h0;
         hold_reg  <= 1'b0;
         done_reg  <= 1'b0;
      end else begin
         done_reg <= 1'b0;
         if (start) begin
            // restart discards any step in flight
            trial_reg <= 10'h200;
            bit_reg   <= 10'h200;
            cnt_reg   <= `ARR_SAR_CYCLES;
            hold_reg  <= 1'b1;
         end else if (hold_reg) begin
            // the trial code reaches the comparator through a register, so
            // the answer is only valid one cycle after each trial change
            hold_reg <= 1'b0;
         end else if (cnt_reg != 4'h0) begin
            // keep bit when input is above trial, then try next bit
            trial_reg <= (cmp_hi ? trial_reg : (trial_reg & ~bit_reg)) | (bit_reg >> 1);
            bit_reg   <= bit_reg >> 1;
            cnt_reg   <= cnt_reg - 4'h1;
            hold_reg  <= 1'b1;
            if (cnt_reg == 4'h1) begin
               done_reg <= 1'b1;
            end
         end
      end
   end
endmodule // arr_sar_step

// file: testbench/arr_front_model.sv
`timescale 1ns/1ps
// far side: four steady input voltages held as ten-bit codes, plus the comparator
module arr_front_model #(
   parameter [39:0] LEVELS = 40'h0   // channel n at bits n*10 up
) (
   // converter side
   input  wire [9:0] dac_code,
   input  wire [1:0] mux_channel,
   // comparator answer
   output wire       cmp_hi
);
   wire [9:0] level;                 // voltage on the selected pin
   assign level = LEVELS[mux_channel * 10 +: 10];
   assign cmp_hi = (level >= dac_code);
endmodule // arr_front_model

// file: testbench/arr_result_regs_chk.sv
`timescale 1ns/1ps
// pin-level checks on the register port; only the block's own outputs are judged
module arr_chk (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [3:0]  analog_pin_level,
   input wire logic        conversion_done_interrupt
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence acc_s; psel && penable && pready; endsequence
   sequence rd_s; psel && penable && pready && !pwrite; endsequence
   chk_ready_cause: assert property (pready |-> $past(psel && !penable))
      else $error("ready without setup");
   chk_ready_pulse: assert property (acc_s |=> !pready)
      else $error("ready held too long");
   chk_low_fill: assert property (rd_s ##0 (paddr[7:3] == 5'h0C && !paddr[0]) |-> prdata[5:0] == 6'h3F)
      else $error("low byte fill bits wrong");
   chk_result_ro: assert property (acc_s ##0 (pwrite && paddr[7:3] == 5'h0C) |-> pslverr)
      else $error("result write accepted");
   chk_result_ok: assert property (rd_s ##0 (paddr[7:3] == 5'h0C) |-> !pslverr)
      else $error("result read refused");
   chk_unmapped_err: assert property (acc_s ##0 (paddr > 8'h74 || paddr < 8'h60) |-> pslverr)
      else $error("unmapped access accepted");
   chk_pin_level: assert property (rd_s ##0 (paddr == 8'h74) |-> prdata[3:0] == $past(analog_pin_level, 2))
      else $error("pin levels misread");
   chk_start_zero: assert property (rd_s ##0 (paddr == 8'h68) |-> !prdata[0])
      else $error("start bit reads one");
   chk_high_clears: assert property (rd_s ##0 (paddr[7:3] == 5'h0C && paddr[0]) |-> ##2 !conversion_done_interrupt)
      else $error("high read left interrupt");
endmodule // arr_chk
bind arr_result_regs arr_chk arr_chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
   .pslverr, .analog_pin_level, .conversion_done_interrupt);

// file: testbench/test_arr_result_regs.sv
`timescale 1ns/1ps
`include "arr_consts.vh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_total++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module test_arr_result_regs;
   // ----------------------------------------
   // stimulus and wiring
   // ----------------------------------------
   localparam [39:0] LV = {10'h3C5, 10'h2A7, 10'h15A, 10'h0FF}; // ch3..ch0 voltages
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, cmp_hi, conversion_done_interrupt;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  pins;
   logic [9:0]  dac_code;
   logic [1:0]  mux_channel;
   logic        er;
   logic        cmp_en;
   int          err_total = 0, total_checks = 0, cyc = 0;
   arr_result_regs arr_result_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cmp_hi(cmp_hi), .analog_pin_level(pins), .dac_code(dac_code), .mux_channel(mux_channel),
      .comparator_enable(cmp_en), .conversion_done_interrupt(conversion_done_interrupt));
   arr_front_model #(.LEVELS(LV)) arr_front_model_i (.dac_code(dac_code), .mux_channel(mux_channel),
      .cmp_hi(cmp_hi));
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   task automatic conclude;
      if (err_total == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // hang guard: whole run needs a few hundred cycles
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         conclude;
      end
   end
   // one apb transfer; an idle cycle after it keeps drivers single per step
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk) penable <= 1'b1;
      // only the run's cycle ceiling ends a wait for ready
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata; er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
      xfer(1'b0, a, 32'h0);
      `CHK(rd[7:0] & m, e)
   endtask
   // poll status until busy drops; a hang is caught by the cycle ceiling
   task automatic wait_idle;
      do xfer(1'b0, `ARR_OFS_STAT, 32'h0); while (rd[`ARR_ST_BUSY] !== 1'b0);
   endtask
   // start a conversion, then wait for it to end
   task automatic conv(input logic [7:0] mode);
      xfer(1'b1, `ARR_OFS_MODE, {24'h0, mode});
      rchk(`ARR_OFS_STAT, 8'h04, 8'h04);
      `CHK(cmp_en, mode[`ARR_MODE_SPEED])
      wait_idle;
   endtask
   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0; pwdata = 32'h0; pins = 4'hA;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rchk(`ARR_OFS_STAT, 8'h00, 8'h07);
      rchk(`ARR_OFS_PORT, 8'h0A, 8'h0F);
      pins <= 4'h5;
      repeat (2) @(posedge pclk);
      rchk(`ARR_OFS_PORT, 8'h05, 8'h0F);
      xfer(1'b1, `ARR_OFS_IMASK, 32'h3);
      conv(8'h39); // fixed channel 3, fast
      `CHK(conversion_done_interrupt, 1'b1)
      rchk(`ARR_OFS_STAT, 8'h03, 8'h07);
      rchk(`ARR_OFS_MODE, 8'h38, 8'hFF);
      rchk(`ARR_OFS_RES0H, 8'h00, 8'hFF);
      rchk(`ARR_OFS_RES3L, {LV[31:30], 6'h3F}, 8'hFF);
      rchk(`ARR_OFS_RES3H, LV[39:32], 8'hFF);
      rchk(`ARR_OFS_STAT, 8'h00, 8'h03);
      `CHK(conversion_done_interrupt, 1'b0)
      conv(8'h3B); // scan all four channels
      for (int i = 0; i < 4; i++) begin
         rchk(8'(8'h60 + 2 * i), {LV[i * 10 +: 2], 6'h3F}, 8'hFF);
         rchk(8'(8'h61 + 2 * i), LV[i * 10 + 2 +: 8], 8'hFF);
      end
      // masked run, restarted while busy
      xfer(1'b1, `ARR_OFS_IMASK, 32'h0);
      xfer(1'b1, `ARR_OFS_MODE, 32'h1B);
      conv(8'h1B);
      `CHK(conversion_done_interrupt, 1'b0)
      rchk(`ARR_OFS_STAT, 8'h03, 8'h07);
      xfer(1'b1, `ARR_OFS_STAT, 32'h3);
      rchk(`ARR_OFS_STAT, 8'h00, 8'h03);
      // repeat on channel two stays busy with no flags until switched off
      xfer(1'b1, `ARR_OFS_MODE, 32'h2D);
      repeat (60) @(posedge pclk);
      rchk(`ARR_OFS_STAT, 8'h04, 8'h07);
      xfer(1'b1, `ARR_OFS_MODE, 32'h28);
      wait_idle;
      rchk(`ARR_OFS_STAT, 8'h03, 8'h07);
      rchk(`ARR_OFS_RES2H, LV[29:22], 8'hFF);
      xfer(1'b1, `ARR_OFS_MODE, 32'h0);
      `CHK(cmp_en, 1'b0)
      xfer(1'b1, `ARR_OFS_RES0H, 32'hFF);
      `CHK(er, 1'b1)
      rchk(`ARR_OFS_RES0H, LV[9:2], 8'hFF);
      xfer(1'b0, 8'h7C, 32'h0);
      `CHK(er, 1'b1)
      xfer(1'b0, 8'h40, 32'h0);
      `CHK(er, 1'b1)
      conclude;
   end
endmodule // test_arr_result_regs
